// ### hw/scs_pkg.sv
// scs_pkg: constants and types shared by the clock source and start-up block
// assumes a single 200 MHz system clock; fuse inputs are static
package scs_pkg;

    // clock source selection field width and codes
    localparam int unsigned SRC_W              = 4;
    localparam logic [3:0]  SRC_XTAL_LO        = 4'ha;
    localparam logic [3:0]  SRC_LFXTAL         = 4'h9;
    localparam logic [3:0]  SRC_EXTRC_HI       = 4'h8;
    localparam logic [3:0]  SRC_EXTRC_LO       = 4'h5;
    localparam logic [3:0]  SRC_INTRC_HI       = 4'h4;
    localparam logic [3:0]  SRC_INTRC_LO       = 4'h1;
    localparam logic [3:0]  SRC_EXTCLK         = 4'h0;

    // factory fuse values: internal rc, longest start-up
    localparam logic [3:0]  SRC_FACTORY        = 4'h1;
    localparam logic [1:0]  SUT_FACTORY        = 2'h2;

    // reset delay in watchdog oscillator cycles
    localparam int unsigned RST_DLY_SHORT      = 4096;
    localparam int unsigned RST_DLY_LONG       = 65536;
    localparam int unsigned RST_CNT_W          = 17;

    // wake start-up cycle counts of the selected source
    localparam int unsigned WAKE_258           = 258;
    localparam int unsigned WAKE_1K            = 1024;
    localparam int unsigned WAKE_16K           = 16384;
    localparam int unsigned WAKE_32K           = 32768;
    localparam int unsigned WAKE_INTRC         = 6;
    localparam int unsigned WAKE_CNT_W         = 16;

    // oscillator kinds
    typedef enum logic [4:0] {
        SCS_OSC_XTAL   = 5'h01,
        SCS_OSC_LFXTAL = 5'h02,
        SCS_OSC_EXTRC  = 5'h04,
        SCS_OSC_INTRC  = 5'h08,
        SCS_OSC_EXTCLK = 5'h10
    } scs_osc_t;

    // sleep modes seen by the clock gates
    typedef enum logic [2:0] {
        SCS_SLP_IDLE  = 3'h0,
        SCS_SLP_ADCNR = 3'h1,
        SCS_SLP_PDOWN = 3'h2,
        SCS_SLP_PSAVE = 3'h3,
        SCS_SLP_STBY  = 3'h6,
        SCS_SLP_XSTBY = 3'h7
    } scs_slp_t;

    // sequencer states
    typedef enum logic [3:0] {
        SCS_ST_RST  = 4'h1,
        SCS_ST_RUN  = 4'h2,
        SCS_ST_SLP  = 4'h4,
        SCS_ST_WAKE = 4'h8
    } scs_state_t;

    // decode the source field; a zero bit means programmed
    function automatic scs_osc_t scs_decode(input logic [3:0] sel);
        if (sel >= SRC_XTAL_LO)
            return SCS_OSC_XTAL;
        else if (sel == SRC_LFXTAL)
            return SCS_OSC_LFXTAL;
        else if (sel >= SRC_EXTRC_LO)
            return SCS_OSC_EXTRC;
        else if (sel >= SRC_INTRC_LO)
            return SCS_OSC_INTRC;
        else
            return SCS_OSC_EXTCLK;
    endfunction

endpackage

// ### hw/scs_clk_gate.sv
// scs_clk_gate: glitch-free clock enable for one clock domain
// assumes the gated clock is produced from i_clk by a latch-free enable;
// the enable is registered so it changes only on a clock edge
`timescale 1ns/1ps
module scs_clk_gate
    import scs_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_run,
    output logic      o_en
);
    logic en_r;
    logic en_nxt;

    // next enable follows i_run; the register clears it in reset
    always_comb begin
        en_nxt = i_run;
    end

    // register so the enable never toggles mid-cycle
    always_ff @(posedge i_clk) begin
        if (!i_rst_n)
            en_r <= 1'b0;
        else
            en_r <= en_nxt;
    end

    assign o_en = en_r;
endmodule // scs_clk_gate

// ### hw/scs_clock_ctrl.sv
// scs_clock_ctrl: clock source decode, start-up timing and domain gating
// assumes fuse inputs are static, wdt_tick and src_tick are one-cycle
// enables from the respective oscillators, and inputs are synchronous
`timescale 1ns/1ps
module scs_clock_ctrl
    import scs_pkg::*;
#(
    parameter int unsigned RST_SHORT = RST_DLY_SHORT,
    parameter int unsigned RST_LONG  = RST_DLY_LONG,
    parameter int unsigned WAKE_SLOW = WAKE_16K
)(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic [3:0] i_clock_source_select,
    input  wire logic [1:0] i_startup_time_select,
    input  wire logic       i_wdt_tick,
    input  wire logic       i_src_tick,
    input  wire logic       i_sleep_req,
    input  wire logic [2:0] i_sleep_mode,
    input  wire logic       i_wake,
    input  wire logic       i_nvm_write_busy,
    input  wire logic       i_ext_irq_async,
    input  wire logic       i_twi_addr_match,
    output logic [4:0]      o_osc_sel,
    output logic            o_osc_run,
    output logic            o_core_clk_en,
    output logic            o_io_clk_en,
    output logic            o_flash_clk_en,
    output logic            o_async_timer_clk_en,
    output logic            o_adc_clk_en,
    output logic            o_exec_hold,
    output logic            o_async_wake
);
    scs_state_t           st_r, st_nxt;
    logic [RST_CNT_W-1:0] rcnt_r, rcnt_nxt;
    logic [WAKE_CNT_W-1:0] wcnt_r, wcnt_nxt;
    logic [2:0]           mode_r, mode_nxt;
    scs_osc_t             osc;
    logic [RST_CNT_W-1:0] rst_target;
    logic [WAKE_CNT_W-1:0] wake_target;
    logic                 deep;
    logic                 keep_r, keep_nxt;
    logic                 run_core, run_io, run_adc, run_asy;

    // fuses read as-is: one means unprogrammed
    assign osc = scs_decode(i_clock_source_select);
    assign o_osc_sel = osc;

    // reset delay: short for sut 00 and 11, long otherwise
    assign rst_target = (i_startup_time_select == 2'h0 ||
                         i_startup_time_select == 2'h3)
                        ? RST_CNT_W'(RST_SHORT) : RST_CNT_W'(RST_LONG);

    // wake count picked from the selected source and start-up field
    always_comb begin
        wake_target = WAKE_CNT_W'(WAKE_INTRC);
        unique case (osc)
            SCS_OSC_XTAL: begin
                if (!i_clock_source_select[0])
                    wake_target = (i_startup_time_select[1])
                        ? WAKE_CNT_W'(WAKE_1K) : WAKE_CNT_W'(WAKE_258);
                else
                    wake_target = (i_startup_time_select == 2'h0)
                        ? WAKE_CNT_W'(WAKE_1K) : WAKE_CNT_W'(WAKE_SLOW);
            end
            SCS_OSC_LFXTAL: begin
                wake_target = (i_startup_time_select[1])
                    ? WAKE_CNT_W'(WAKE_32K) : WAKE_CNT_W'(WAKE_1K);
            end
            SCS_OSC_EXTRC, SCS_OSC_INTRC, SCS_OSC_EXTCLK: begin
                wake_target = WAKE_CNT_W'(WAKE_INTRC);
            end
        endcase
    end

    // power-down and power-save stop the source oscillator
    assign deep = (mode_r == SCS_SLP_PDOWN) || (mode_r == SCS_SLP_PSAVE);

    // sequencer next state
    always_comb begin
        st_nxt   = st_r;
        rcnt_nxt = rcnt_r;
        wcnt_nxt = wcnt_r;
        mode_nxt = mode_r;
        unique case (st_r)
            SCS_ST_RST: begin
                if (i_wdt_tick) begin
                    rcnt_nxt = rcnt_r + RST_CNT_W'(1);
                    if (rcnt_nxt >= rst_target)
                        st_nxt = SCS_ST_RUN;
                end
            end
            SCS_ST_RUN: begin
                if (i_sleep_req) begin
                    mode_nxt = i_sleep_mode;
                    st_nxt   = SCS_ST_SLP;
                end
            end
            SCS_ST_SLP: begin
                wcnt_nxt = '0;
                if (i_wake || i_ext_irq_async || i_twi_addr_match)
                    st_nxt = deep ? SCS_ST_WAKE : SCS_ST_RUN;
            end
            SCS_ST_WAKE: begin
                if (i_src_tick) begin
                    wcnt_nxt = wcnt_r + WAKE_CNT_W'(1);
                    if (wcnt_nxt >= wake_target)
                        st_nxt = SCS_ST_RUN;
                end
            end
            default: st_nxt = SCS_ST_RST;
        endcase
        // a write caught in sleep pins the oscillator until wake
        keep_nxt = (st_nxt == SCS_ST_SLP) && (keep_r || i_nvm_write_busy);
    end

    // sequencer registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_r   <= SCS_ST_RST;
            rcnt_r <= '0;
            wcnt_r <= '0;
            mode_r <= SCS_SLP_IDLE;
            keep_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            rcnt_r <= rcnt_nxt;
            wcnt_r <= wcnt_nxt;
            mode_r <= mode_nxt;
            keep_r <= keep_nxt;
        end
    end

    // domain run requests per sleep mode; all off until start-up
    always_comb begin
        run_core = (st_r == SCS_ST_RUN);
        run_io   = run_core;
        run_adc  = run_core;
        run_asy  = run_core;
        if (st_r == SCS_ST_SLP) begin
            run_io  = (mode_r == SCS_SLP_IDLE);
            run_adc = (mode_r == SCS_SLP_IDLE) ||
                      (mode_r == SCS_SLP_ADCNR);
            run_asy = (mode_r != SCS_SLP_PDOWN) &&
                      (mode_r != SCS_SLP_STBY);
        end
    end

    // oscillator stays up unless deep sleep; a write keeps it, even
    // after the write ends, until the sequencer leaves sleep
    assign o_osc_run = (st_r != SCS_ST_SLP) || !deep ||
                       (mode_r == SCS_SLP_STBY) ||
                       (mode_r == SCS_SLP_XSTBY) || i_nvm_write_busy ||
                       keep_r;

    // registered enables avoid runt pulses on the gated clocks
    scs_clk_gate u_gate_core (
        .i_clk  (i_clk),
        .i_rst_n(i_rst_n),
        .i_run  (run_core),
        .o_en   (o_core_clk_en)
    );
    scs_clk_gate u_gate_flash (
        .i_clk  (i_clk),
        .i_rst_n(i_rst_n),
        .i_run  (run_core),
        .o_en   (o_flash_clk_en)
    );
    scs_clk_gate u_gate_io (
        .i_clk  (i_clk),
        .i_rst_n(i_rst_n),
        .i_run  (run_io),
        .o_en   (o_io_clk_en)
    );
    scs_clk_gate u_gate_adc (
        .i_clk  (i_clk),
        .i_rst_n(i_rst_n),
        .i_run  (run_adc),
        .o_en   (o_adc_clk_en)
    );
    scs_clk_gate u_gate_asy (
        .i_clk  (i_clk),
        .i_rst_n(i_rst_n),
        .i_run  (run_asy),
        .o_en   (o_async_timer_clk_en)
    );

    // execution held whenever the core is not released
    assign o_exec_hold  = !o_core_clk_en;
    // async sources reach the wake logic with no io clock
    assign o_async_wake = i_ext_irq_async | i_twi_addr_match;

    // assertions share one clock and the synchronous reset
    default clocking cb_chk @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    // reset delay end: last watchdog tick, then the core released
    sequence s_rst_last_tick;
        st_r == SCS_ST_RST && i_wdt_tick &&
        (rcnt_r + RST_CNT_W'(1)) >= rst_target;
    endsequence
    sequence s_run_then_core;
        (st_r == SCS_ST_RUN) ##1 o_core_clk_en;
    endsequence

    // a write seen in sleep, then still asleep
    sequence s_busy_in_sleep;
        (st_r == SCS_ST_SLP && i_nvm_write_busy) ##1 (st_r == SCS_ST_SLP);
    endsequence

    // wake count finished and the sequencer back in run
    sequence s_wake_done;
        (st_r == SCS_ST_WAKE) ##1 (st_r == SCS_ST_RUN);
    endsequence

    // nothing runs while the reset delay counts
    a_rst_hold_core: assert property (
        (st_r == SCS_ST_RST) |=> !o_core_clk_en)
        else $error("core clock enabled during reset delay");

    // program memory clock moves with the core clock
    a_flash_follows: assert property (
        o_flash_clk_en == o_core_clk_en)
        else $error("flash clock not tracking core clock");

    // terminal watchdog count releases the core two cycles later
    a_rst_done_run: assert property (
        s_rst_last_tick |=> s_run_then_core)
        else $error("reset delay end not releasing core");

    // no execution while the source settles after wake
    a_wake_hold_exec: assert property (
        (st_r == SCS_ST_WAKE) |=> o_exec_hold)
        else $error("execution during wake start-up");

    // a busy memory write never loses its oscillator
    a_nvm_keeps_osc: assert property (
        i_nvm_write_busy |-> o_osc_run)
        else $error("oscillator stopped during memory write");

    // noise reduction keeps only the converter and timer clocks
    a_adc_noise_red: assert property (
        (st_r == SCS_ST_SLP && mode_r == SCS_SLP_ADCNR) [*2]
        |-> o_adc_clk_en && !o_io_clk_en)
        else $error("converter noise mode gating wrong");

    // power-down stops the io and async timer domains
    a_pdown_io_off: assert property (
        (st_r == SCS_ST_SLP && mode_r == SCS_SLP_PDOWN) [*2]
        |-> !o_io_clk_en && !o_async_timer_clk_en)
        else $error("clocks running in power-down");

    // the real-time counter keeps its clock in power-save
    a_psave_asy_on: assert property (
        (st_r == SCS_ST_SLP && mode_r == SCS_SLP_PSAVE) [*2]
        |-> o_async_timer_clk_en)
        else $error("async timer stopped in power-save");

    // an address match leaves sleep with the io clock stopped
    a_twi_wakes: assert property (
        (st_r == SCS_ST_SLP && i_twi_addr_match) |=> (st_r != SCS_ST_SLP))
        else $error("address match did not wake");

    // top codes select the crystal or resonator
    a_decode_xtal: assert property (
        (i_clock_source_select >= SRC_XTAL_LO)
        |-> (o_osc_sel == SCS_OSC_XTAL))
        else $error("crystal code decoded wrong");

    // the oscillator outlives a write that started in sleep
    a_write_osc_held: assert property (
        s_busy_in_sleep |-> o_osc_run)
        else $error("oscillator stopped after write in sleep");

    // without a write, power-down really stops the oscillator
    a_pdown_osc_off: assert property (
        (st_r == SCS_ST_SLP && mode_r == SCS_SLP_PDOWN &&
         !keep_r && !i_nvm_write_busy) |-> !o_osc_run)
        else $error("oscillator running in power-down");

    // every domain comes back together after the wake count
    a_wake_release: assert property (
        s_wake_done |=> o_core_clk_en && o_io_clk_en &&
                        o_adc_clk_en && o_async_timer_clk_en)
        else $error("domains not released together after wake");

    // core and program memory clocks stop in every sleep mode
    a_sleep_core_off: assert property (
        (st_r == SCS_ST_SLP) [*2]
        |-> !o_core_clk_en && !o_flash_clk_en)
        else $error("core clock running in sleep");

    // idle keeps the peripherals clocked
    a_idle_io_on: assert property (
        (st_r == SCS_ST_SLP && mode_r == SCS_SLP_IDLE) [*2]
        |-> o_io_clk_en && o_adc_clk_en)
        else $error("io clock stopped in idle");

    // an asynchronous external interrupt wakes the device
    a_irq_wakes: assert property (
        (st_r == SCS_ST_SLP && i_ext_irq_async) |=> (st_r != SCS_ST_SLP))
        else $error("external interrupt did not wake");

    // deep sleep wakes through the start-up count, not straight to run
    a_deep_wake_wait: assert property (
        (st_r == SCS_ST_SLP && deep && i_wake) |=> (st_r == SCS_ST_WAKE))
        else $error("deep sleep woke without start-up count");
endmodule // scs_clock_ctrl

// ### tb/test_system_clock_source_and_startup.sv
// bench for scs_clock_ctrl: decode, reset delay, sleep gating and wake
// assumes shortened reset delays; inputs move on the falling clock edge
`timescale 1ns/1ps
module test_system_clock_source_and_startup;
    import scs_pkg::*;
    localparam int unsigned P_SHORT = 8;
    localparam int unsigned P_LONG  = 16;
    logic       i_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [3:0] cks   = SRC_FACTORY;
    logic [1:0] startup_time_select   = SUT_FACTORY;
    logic       wdt   = 1'b0;
    logic       src   = 1'b0;
    logic       req   = 1'b0;
    logic [2:0] mode  = 3'h0;
    logic       wake  = 1'b0;
    logic       nvm   = 1'b0;
    logic       irq   = 1'b0;
    logic       two_wire_serial   = 1'b0;
    logic [4:0] osc_sel;
    logic       osc_run, core, io, flash, asy, adc, hold, awake;
    int         n_fail = 0;
    int         checks = 0;

    // 200 MHz clock
    always #2.5 i_clk = ~i_clk;

    scs_clock_ctrl #(.RST_SHORT(P_SHORT), .RST_LONG(P_LONG),
                     .WAKE_SLOW(12)) uut (
        .i_clk(i_clk), .i_rst_n(rst_n), .i_clock_source_select(cks),
        .i_startup_time_select(startup_time_select), .i_wdt_tick(wdt), .i_src_tick(src),
        .i_sleep_req(req), .i_sleep_mode(mode), .i_wake(wake),
        .i_nvm_write_busy(nvm), .i_ext_irq_async(irq),
        .i_twi_addr_match(two_wire_serial), .o_osc_sel(osc_sel), .o_osc_run(osc_run),
        .o_core_clk_en(core), .o_io_clk_en(io), .o_flash_clk_en(flash),
        .o_async_timer_clk_en(asy), .o_adc_clk_en(adc),
        .o_exec_hold(hold), .o_async_wake(awake));

    // domain enables packed core, flash, io, adc, async timer
    function automatic logic [7:0] ens();
        return {3'h0, core, flash, io, adc, asy};
    endfunction

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // ticks fed every other cycle until execution is released
    task automatic count_ticks(input bit use_wdt, output int n);
        n = 0;
        for (int k = 0; k < 200; k++) begin
            @(negedge i_clk);
            if (hold === 1'b0) return;
            if (use_wdt) wdt = 1'b1;
            else src = 1'b1;
            @(negedge i_clk);
            wdt = 1'b0;
            src = 1'b0;
            n++;
        end
        n_fail++;
        close_out();
    endtask

    task automatic t_reset(input logic [1:0] s, input int exp);
        int n;
        rst_n = 1'b0;
        startup_time_select = s;
        repeat (12) @(negedge i_clk);
        chk("domains in reset", 8'h00, ens());
        chk("hold in reset", 8'h01, {7'h0, hold});
        rst_n = 1'b1;
        count_ticks(1'b1, n);
        chk("reset delay ticks", exp[7:0], n[7:0]);
        chk("domains after reset", 8'h1f, ens());
        $display("reset test, start-up field %b, done", s);
    endtask

    // only a table of decode results is expected, computed here
    task automatic t_decode;
        logic [4:0] e;
        for (int c = 0; c < 16; c++) begin
            @(negedge i_clk);
            cks = c[3:0];
            e = (c >= 10) ? 5'h01 : (c == 9) ? 5'h02 :
                (c >= 5) ? 5'h04 : (c >= 1) ? 5'h08 : 5'h10;
            #1;
            chk("oscillator kind", {3'h0, e}, {3'h0, osc_sel});
        end
        cks = SRC_FACTORY;
        $display("decode test done");
    endtask

    // sleep in mode m, check gates, wake from source ws (0 wake,1 irq,2 twi)
    task automatic t_sleep(input logic [2:0] m, input logic [4:0] e_en,
                           input logic e_osc, input int ws, input bit nv);
        int n;
        @(negedge i_clk);
        nvm = nv;
        req = 1'b1;
        mode = m;
        @(negedge i_clk);
        req = 1'b0;
        repeat (3) @(negedge i_clk);
        chk("sleep domains", {3'h0, e_en}, ens());
        chk("oscillator run", {7'h0, e_osc}, {7'h0, osc_run});
        if (nv) begin
            nvm = 1'b0;
            repeat (4) @(negedge i_clk);
            chk("osc after write", 8'h01, {7'h0, osc_run});
        end
        wake = (ws == 0);
        irq = (ws == 1);
        two_wire_serial = (ws == 2);
        #1;
        chk("async wake", {7'h0, ws != 0}, {7'h0, awake});
        count_ticks(1'b0, n);
        wake = 1'b0;
        irq = 1'b0;
        two_wire_serial = 1'b0;
        if (m == SCS_SLP_PDOWN || m == SCS_SLP_PSAVE)
            chk("wake ticks", 8'h06, n[7:0]);
        chk("domains after wake", 8'h1f, ens());
        $display("sleep test, mode %0d, done", m);
    endtask

    initial begin
        t_reset(SUT_FACTORY, P_LONG);
        t_decode();
        t_reset(2'h0, P_SHORT);
        t_reset(2'h1, P_LONG);
        t_reset(2'h3, P_SHORT);
        t_sleep(SCS_SLP_IDLE, 5'h07, 1'b1, 0, 1'b0);
        t_sleep(SCS_SLP_ADCNR, 5'h03, 1'b1, 1, 1'b0);
        t_sleep(SCS_SLP_PDOWN, 5'h00, 1'b0, 2, 1'b0);
        t_sleep(SCS_SLP_PSAVE, 5'h01, 1'b0, 0, 1'b0);
        t_sleep(SCS_SLP_STBY, 5'h00, 1'b1, 1, 1'b0);
        t_sleep(SCS_SLP_XSTBY, 5'h01, 1'b1, 0, 1'b0);
        t_sleep(SCS_SLP_PDOWN, 5'h00, 1'b1, 0, 1'b1);
        close_out();
    end
endmodule // test_system_clock_source_and_startup
